/* File: misc_cfg_defines.vh */
// Constants for the miscellaneous configuration register block
//
// Operation
// - Register at command A0h, single-byte write and read, with nonvolatile copy.
// - Bit 7 clear gives discontinuous mode at light load; set forces continuous.
// - Source 00b: serial VID sets voltage and offset; A6h ignored, A8h writes NACKed.
// - Source 01b: serial VID voltage, I2C offset; serial offset 33h writes ignored.
// - Source 10b/11b: I2C setpoint and offset rule; serial writes cannot change output.
// - Soft-stop bit 0: switching stops at once, no ramp, delay taken as zero.
// - Soft-stop bit 1: wait turn-off delay, then ramp down, then stop switching.
// - Bits 3:2 pick ready rise delay 0, 0.5, 1.0 or 2.0 ms.
// - Bit 0 picks bus address from strap pin or nonvolatile copy.
// - Bit 1 is reserved: stored, no function.
// - Writes stored once the nonvolatile copy has loaded; bits 7:1 take effect only while switching disabled, not always-on; bit 0 only after reload.
`ifndef MISC_CFG_DEFINES_VH
`define MISC_CFG_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_MISC_CFG 8'hA0
`define CMD_SETPOINT 8'hA6
`define CMD_BUS_OFFSET 8'hA8
`define CMD_SAVE_ALL 8'h15

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_FORCED_CONT 7
`define FLD_SRC_HI 6
`define FLD_SRC_LO 5
`define FLD_SOFT_STOP 4
`define FLD_RDY_HI 3
`define FLD_RDY_LO 2
`define FLD_VID_ADDR_OVR 1
`define FLD_BUS_ADDR_OVR 0

// ----------------------------------------
// Voltage source codes
// ----------------------------------------
`define SRC_ALL_VID 2'h0
`define SRC_VID_OFS_BUS 2'h1

// ----------------------------------------
// Timing, clock 125 MHz
// ----------------------------------------
`define CLK_KHZ 125000
`define DLY_HALF_MS_US 500
`define DLY_HALF_MS_CYC ((`DLY_HALF_MS_US * `CLK_KHZ) / 1000)
`define TICK_W 16
`define RDY_CNT_W 3
`define RDY_UNITS_0 3'h0
`define RDY_UNITS_1 3'h1
`define RDY_UNITS_2 3'h2
`define RDY_UNITS_3 3'h4

`endif

/* File: ready_delay_timer.v */
// Ready rise delay timer counting half-millisecond units
`timescale 1ns/100ps
`default_nettype none
`include "misc_cfg_defines.vh"
module ready_delay_timer (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Control
  input wire start,
  input wire clear,
  input wire [1:0] delay_sel,
  // Result
  output reg done_r
);
  reg [`TICK_W-1:0] tick_r;
  reg [`RDY_CNT_W-1:0] units_r;
  reg run_r;
  reg [`RDY_CNT_W-1:0] target;

  // ----------------------------------------
  // Delay code to units
  // ----------------------------------------
  always @* begin
    case (delay_sel)
      2'h0: target = `RDY_UNITS_0;
      2'h1: target = `RDY_UNITS_1;
      2'h2: target = `RDY_UNITS_2;
      default: target = `RDY_UNITS_3;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst || clear) begin
      tick_r <= {`TICK_W{1'b0}};
      units_r <= {`RDY_CNT_W{1'b0}};
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start && !run_r && !done_r) begin
      run_r <= (target != `RDY_UNITS_0);
      done_r <= (target == `RDY_UNITS_0);
      tick_r <= {`TICK_W{1'b0}};
      units_r <= {`RDY_CNT_W{1'b0}};
    end else if (run_r) begin
      if (tick_r == `DLY_HALF_MS_CYC - 1) begin
        tick_r <= {`TICK_W{1'b0}};
        if (units_r + 3'h1 == target) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
        units_r <= units_r + 3'h1;
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: misc_config_reg.v */
// Miscellaneous configuration register and the behaviour it steers
`timescale 1ns/100ps
`default_nettype none
`include "misc_cfg_defines.vh"
module misc_config_reg (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Decoded byte command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_wdata,
  output reg cmd_ack_r,
  output reg cmd_nack_r,
  output reg [7:0] cmd_rdata_r,
  // Nonvolatile copy
  input wire [7:0] nvm_value,
  input wire nvm_valid,
  // Switching state
  input wire switching_on,
  input wire always_on_policy,
  input wire turn_off_req,
  input wire turn_off_delay_done,
  input wire turn_off_ramp_done,
  input wire soft_start_done,
  input wire [6:0] strap_addr,
  input wire [6:0] nvm_addr,
  // Serial VID side
  input wire vid_setpoint_wr,
  input wire vid_offset_wr,
  // Effective controls
  output reg forced_continuous_mode_r,
  output reg [1:0] output_voltage_source_select_r,
  output reg vid_setpoint_en_r,
  output reg vid_offset_en_r,
  output reg bus_setpoint_en_r,
  output reg bus_offset_en_r,
  output reg turn_off_delay_run_r,
  output reg turn_off_ramp_run_r,
  output reg switching_stop_r,
  output reg regulator_ready_pin_r,
  output reg [6:0] bus_addr_r
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_DELAY = 4'b0010;
  localparam ST_RAMP = 4'b0100;
  localparam ST_STOP = 4'b1000;

  reg [7:0] misc_system_config_r;
  reg [7:0] active_r;
  reg loaded_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  wire rdy_done;
  wire hit;
  wire may_apply;

  assign hit = cmd_valid && (cmd_code == `CMD_MISC_CFG);
  // Settings only latch while the stage is idle, avoiding glitches in regulation
  assign may_apply = !switching_on && !always_on_policy;

  // ----------------------------------------
  // Register store and command answers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      misc_system_config_r <= 8'h00;
      active_r <= 8'h00;
      loaded_r <= 1'b0;
      cmd_ack_r <= 1'b0;
      cmd_nack_r <= 1'b0;
      cmd_rdata_r <= 8'h00;
    end else begin
      cmd_ack_r <= 1'b0;
      cmd_nack_r <= 1'b0;
      if (!loaded_r) begin
        if (nvm_valid) begin
          misc_system_config_r <= nvm_value;
          active_r <= nvm_value;
          loaded_r <= 1'b1;
        end
      end else begin
        if (hit && cmd_write) begin
          misc_system_config_r <= cmd_wdata;
          cmd_ack_r <= 1'b1;
        end else if (hit) begin
          cmd_rdata_r <= misc_system_config_r;
          cmd_ack_r <= 1'b1;
        end else if (cmd_valid && cmd_write && cmd_code == `CMD_BUS_OFFSET &&
                     active_r[`FLD_SRC_HI:`FLD_SRC_LO] == `SRC_ALL_VID) begin
          cmd_nack_r <= 1'b1;
        end
        if (may_apply) begin
          // Address override bit waits for a supply cycle, so it stays
          active_r[`FLD_FORCED_CONT:`FLD_VID_ADDR_OVR] <=
            misc_system_config_r[`FLD_FORCED_CONT:`FLD_VID_ADDR_OVR];
        end
      end
    end
  end

  // ----------------------------------------
  // Source selection and mode
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      forced_continuous_mode_r <= 1'b0;
      output_voltage_source_select_r <= 2'h0;
      vid_setpoint_en_r <= 1'b0;
      vid_offset_en_r <= 1'b0;
      bus_setpoint_en_r <= 1'b0;
      bus_offset_en_r <= 1'b0;
      bus_addr_r <= 7'h00;
    end else begin
      forced_continuous_mode_r <= active_r[`FLD_FORCED_CONT];
      output_voltage_source_select_r <= active_r[`FLD_SRC_HI:`FLD_SRC_LO];
      case (active_r[`FLD_SRC_HI:`FLD_SRC_LO])
        `SRC_ALL_VID: begin
          vid_setpoint_en_r <= vid_setpoint_wr;
          vid_offset_en_r <= vid_offset_wr;
          bus_setpoint_en_r <= 1'b0;
          bus_offset_en_r <= 1'b0;
        end
        `SRC_VID_OFS_BUS: begin
          vid_setpoint_en_r <= vid_setpoint_wr;
          vid_offset_en_r <= 1'b0;
          bus_setpoint_en_r <= 1'b0;
          bus_offset_en_r <= 1'b1;
        end
        default: begin
          vid_setpoint_en_r <= 1'b0;
          vid_offset_en_r <= 1'b0;
          bus_setpoint_en_r <= 1'b1;
          bus_offset_en_r <= 1'b1;
        end
      endcase
      bus_addr_r <= active_r[`FLD_BUS_ADDR_OVR] ? nvm_addr : strap_addr;
    end
  end

  // ----------------------------------------
  // Turn-off sequence
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (turn_off_req) begin
          state_nxt = active_r[`FLD_SOFT_STOP] ? ST_DELAY : ST_STOP;
        end
      end
      ST_DELAY: begin
        if (turn_off_delay_done) begin
          state_nxt = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (turn_off_ramp_done) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!turn_off_req) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      turn_off_delay_run_r <= 1'b0;
      turn_off_ramp_run_r <= 1'b0;
      switching_stop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      turn_off_delay_run_r <= (state_nxt == ST_DELAY);
      turn_off_ramp_run_r <= (state_nxt == ST_RAMP);
      switching_stop_r <= (state_nxt == ST_STOP);
    end
  end

  // ----------------------------------------
  // Ready output delay
  // ----------------------------------------
  ready_delay_timer u_rdy (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(soft_start_done),
    .clear(!soft_start_done || turn_off_req),
    .delay_sel(active_r[`FLD_RDY_HI:`FLD_RDY_LO]),
    .done_r(rdy_done)
  );

  always @(posedge clk_sys) begin
    if (srst) begin
      regulator_ready_pin_r <= 1'b0;
    end else begin
      regulator_ready_pin_r <= rdy_done && !turn_off_req;
    end
  end
endmodule
`default_nettype wire

/* File: turn_off_partner.sv */
// Model of the switching stage answering the turn-off phases
`timescale 1ns/100ps
`default_nettype none
module turn_off_partner #(
  parameter int LAT = 6
) (
  // Clock
  input wire logic clk_sys,
  // Phase requests
  input wire logic delay_run,
  input wire logic ramp_run,
  // Phase completion
  output logic delay_done,
  output logic ramp_done
);
  int dc = 0;
  int rc = 0;
  // Separate counters, so a ramp never finishes on the delay's count
  always @(posedge clk_sys) begin
    dc <= delay_run ? dc + 1 : 0;
    rc <= ramp_run ? rc + 1 : 0;
  end
  assign delay_done = dc >= LAT;
  assign ramp_done = rc >= LAT;
endmodule
`default_nettype wire

/* File: misc_config_reg_properties.sv */
// Port checker for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module misc_config_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Inputs watched
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic nvm_valid,
  input wire logic vid_setpoint_wr,
  input wire logic vid_offset_wr,
  input wire logic soft_start_done,
  // Outputs watched
  input wire logic cmd_ack_r,
  input wire logic cmd_nack_r,
  input wire logic [1:0] output_voltage_source_select_r,
  input wire logic vid_setpoint_en_r,
  input wire logic vid_offset_en_r,
  input wire logic bus_setpoint_en_r,
  input wire logic bus_offset_en_r,
  input wire logic turn_off_delay_run_r,
  input wire logic turn_off_ramp_run_r,
  input wire logic switching_stop_r,
  input wire logic regulator_ready_pin_r
);
  logic ld_r;
  wire [1:0] sel = output_voltage_source_select_r;
  // Commands count only once the stored copy has arrived
  always @(posedge clk_sys) ld_r <= srst ? 1'b0 : (ld_r | nvm_valid);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence cfg_req;
    ld_r && cmd_valid && cmd_code == 8'hA0;
  endsequence
  sequence ofs_wr;
    ld_r && cmd_valid && cmd_write && cmd_code == 8'hA8;
  endsequence
  sequence delay_end;
    $fell(turn_off_delay_run_r);
  endsequence
  sequence ramp_end;
    $fell(turn_off_ramp_run_r);
  endsequence
  cfg_ack_a: assert property (cfg_req |=> cmd_ack_r) else $error("config access not acked");
  other_ack_a: assert property (cmd_valid && cmd_code != 8'hA0 |=> !cmd_ack_r)
    else $error("ack for foreign code");
  // Source shown one edge later is the one each write was judged by
  ofs_nack_a: assert property (ofs_wr ##1 (sel == 2'h0) |-> cmd_nack_r)
    else $error("offset write not refused");
  ofs_accept_a: assert property (ofs_wr ##1 (sel != 2'h0) |-> !cmd_nack_r)
    else $error("offset write refused");
  vid_src_a: assert property (sel == 2'h0 [*2] |-> !bus_offset_en_r && !bus_setpoint_en_r)
    else $error("bus steers while serial source");
  bus_src_a: assert property (sel[1] [*2] |-> bus_offset_en_r && bus_setpoint_en_r)
    else $error("bus not steering");
  vid_ofs_a: assert property (vid_offset_wr ##1 (sel != 2'h0) |-> !vid_offset_en_r)
    else $error("serial offset acted");
  vid_set_a: assert property (vid_setpoint_wr ##1 sel[1] |-> !vid_setpoint_en_r)
    else $error("serial setpoint acted");
  off_phase_a: assert property (turn_off_delay_run_r |-> !turn_off_ramp_run_r && !switching_stop_r)
    else $error("turn-off phases overlap");
  // Pin lags the timer by one flop, so three low samples are needed
  ready_drop_a: assert property (!soft_start_done [*3] |-> !regulator_ready_pin_r)
    else $error("ready high without soft start");
  delay_ramp_a: assert property (delay_end |-> turn_off_ramp_run_r)
    else $error("delay not followed by ramp");
  ramp_stop_a: assert property (ramp_end |-> switching_stop_r)
    else $error("ramp not followed by stop");
endmodule
bind misc_config_reg misc_config_props u_props (.*);
`default_nettype wire

/* File: regulator_misc_config_reg_tb_top.sv */
// Testbench for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module regulator_misc_config_reg_tb_top;
  logic clk_sys = 0, srst = 1, cmd_valid = 0, cmd_write = 0, nvm_valid = 0, switching_on = 0;
  logic always_on_policy = 0, turn_off_req = 0, soft_start_done = 0, vs_wr = 0, vo_wr = 0;
  logic ack, nack, fcm, vs_en, vo_en, bs_en, bo_en, d_run, r_run, d_done, r_done, stop, rdy;
  logic [7:0] cmd_code = 0, cmd_wdata = 0, rdata, nvm_val = 8'h21;
  logic [6:0] bus_addr;
  logic [1:0] sel;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  misc_config_reg dut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_r(ack),
    .cmd_nack_r(nack), .cmd_rdata_r(rdata), .nvm_value(nvm_val), .nvm_valid(nvm_valid),
    .switching_on(switching_on), .always_on_policy(always_on_policy),
    .turn_off_req(turn_off_req), .turn_off_delay_done(d_done), .turn_off_ramp_done(r_done),
    .soft_start_done(soft_start_done), .strap_addr(7'h11), .nvm_addr(7'h5A),
    .vid_setpoint_wr(vs_wr), .vid_offset_wr(vo_wr), .forced_continuous_mode_r(fcm),
    .output_voltage_source_select_r(sel), .vid_setpoint_en_r(vs_en), .vid_offset_en_r(vo_en),
    .bus_setpoint_en_r(bs_en), .bus_offset_en_r(bo_en), .turn_off_delay_run_r(d_run),
    .turn_off_ramp_run_r(r_run), .switching_stop_r(stop), .regulator_ready_pin_r(rdy),
    .bus_addr_r(bus_addr));
  turn_off_partner #(.LAT(6)) partner (.clk_sys(clk_sys), .delay_run(d_run),
    .ramp_run(r_run), .delay_done(d_done), .ramp_done(r_done));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Ends on the falling edge where the answer is visible
  task cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(negedge clk_sys);
    cmd_valid = 1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk_sys);
    cmd_valid = 0;
  endtask
  task cfg(input logic [7:0] d);
    cmd(1, 8'hA0, d);
    repeat (3) @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_load;
    cmd(0, 8'hA0, 8'h00);
    chk(ack, 0);
    nvm_valid = 1;
    @(negedge clk_sys);
    nvm_valid = 0;
    cmd(0, 8'hA0, 8'h00);
    chk(rdata, 8'h21);
    repeat (2) @(negedge clk_sys);
    chk(sel, 1);
    chk({1'b0, bus_addr}, 8'h5A);
    $display("test load done");
  endtask
  task t_apply;
    switching_on = 1;
    cmd(1, 8'hA0, 8'hC2);
    chk(ack, 1);
    cmd(0, 8'hA0, 8'h00);
    chk(rdata, 8'hC2);
    repeat (3) @(negedge clk_sys);
    chk(fcm, 0);
    switching_on = 0;
    repeat (3) @(negedge clk_sys);
    chk(fcm, 1);
    chk({bs_en, bo_en, sel}, 8'h0E);
    chk({1'b0, bus_addr}, 8'h5A);
    vs_wr = 1;
    @(negedge clk_sys);
    vs_wr = 0;
    chk(vs_en, 0);
    $display("test apply done");
  endtask
  task t_nack;
    cfg(8'h00);
    cmd(1, 8'hA8, 8'h05);
    chk(nack, 1);
    cfg(8'h20);
    cmd(1, 8'hA8, 8'h05);
    chk(nack, 0);
    vo_wr = 1;
    @(negedge clk_sys);
    vo_wr = 0;
    chk(vo_en, 0);
    $display("test nack done");
  endtask
  task t_off;
    cfg(8'h10);
    turn_off_req = 1;
    repeat (2) @(negedge clk_sys);
    chk({d_run, stop}, 8'h02);
    repeat (8) @(negedge clk_sys);
    chk({d_run, r_run, stop}, 8'h02);
    repeat (12) @(negedge clk_sys);
    chk(stop, 1);
    turn_off_req = 0;
    cfg(8'h00);
    turn_off_req = 1;
    repeat (2) @(negedge clk_sys);
    chk({d_run, stop}, 8'h01);
    turn_off_req = 0;
    $display("test off done");
  endtask
  // Host saves the register, then the supply is cycled
  task t_reload;
    cfg(8'h40);
    cmd(1, 8'h15, 8'h00);
    chk(ack, 0);
    nvm_val = 8'h40;
    chk({1'b0, bus_addr}, 8'h5A);
    srst = 1;
    repeat (3) @(negedge clk_sys);
    srst = 0;
    chk({1'b0, bus_addr}, 8'h00);
    @(negedge clk_sys);
    nvm_valid = 1;
    @(negedge clk_sys);
    nvm_valid = 0;
    repeat (2) @(negedge clk_sys);
    chk({1'b0, bus_addr}, 8'h11);
    chk(sel, 2);
    cmd(0, 8'hA0, 8'h00);
    chk(rdata, 8'h40);
    $display("test reload done");
  endtask
  task t_ready;
    soft_start_done = 1;
    repeat (4) @(negedge clk_sys);
    chk(rdy, 1);
    soft_start_done = 0;
    cfg(8'h04);
    soft_start_done = 1;
    repeat (62499) @(negedge clk_sys);
    chk(rdy, 0);
    repeat (6) @(negedge clk_sys);
    chk(rdy, 1);
    $display("test ready done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard well above the longest delay test
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    srst = 0;
    t_load;
    t_apply;
    t_nack;
    t_off;
    t_reload;
    t_ready;
    final_report;
  end
endmodule
`default_nettype wire
